// ### core/pov_regs.svh
`ifndef POV_REGS_SVH
`define POV_REGS_SVH

// Word and storage geometry
`define POV_WORD_BITS 8
`define POV_DEPTH 16
`define POV_IDX_W 4
`define POV_CNT_W 5
`define POV_DEPTH_CNT 5'h10

// Decoding constants
`define POV_SHOW_CODE 7'h7F
`define POV_ASCII_OFFSET 7'h20
`define POV_LAST_BIT 3'h7
`define POV_CHR_LAST_COL 3'h5
`define POV_BMP_LAST_COL 3'h0

// Reset values
`define POV_RST_LED 8'h00
`define POV_RST_CNT 5'h00
`define POV_RST_SHREG 8'h00
`define POV_RST_BIT 3'h0
`define POV_RST_IDX 4'h0
`define POV_RST_COL 3'h0

`endif

// ### core/pov_pkg.sv
`default_nettype none
`include "pov_regs.svh"

package pov_pkg;
    // Pins that arrive from outside the clock domain
    typedef struct packed {
        logic step;
        logic write;
        logic din;
        logic under;
        logic over;
    } pov_pins_t;

    // Kind of a stored word, from decoded bits 6:5
    typedef enum logic [1:0] {
        POV_KIND_BMP = 2'b00,
        POV_KIND_CHR = 2'b01
    } pov_kind_t;

    // Loading content or showing it
    typedef enum logic {
        POV_ST_LOAD = 1'b0,
        POV_ST_SHOW = 1'b1
    } pov_state_t;

    typedef logic [6:0] pov_word_t;
endpackage : pov_pkg

`default_nettype wire

// ### core/pov_char_rom_serial_shifter.sv
`default_nettype none
`include "pov_regs.svh"

module pov_char_rom_serial_shifter
    import pov_pkg::*;
(
    input wire logic core_clk_i, // 250 MHz core clock
    input wire logic rst_i, // Async reset, active high
    input wire logic step_clk_i, // Step clock pin
    input wire logic write_i, // High shifts in, low plays out
    input wire logic din_i, // Serial data pin
    input wire logic under_i, // Underline for bitmaps
    input wire logic over_i, // Overline for bitmaps
    output logic [7:0] led_o, // LED column
    output logic showing_o // Playback active
);

    // Glyph columns for ASCII 0x20..0x3F, first column in top byte, bit 0 top row
    function automatic logic [39:0] glyph_row(input logic [6:0] ascii);
        logic [39:0] r;
        r = 40'h00_00_00_00_00;
        case (ascii)
            7'h20: r = 40'h00_00_00_00_00;
            7'h21: r = 40'h00_00_5F_00_00;
            7'h22: r = 40'h00_07_00_07_00;
            7'h23: r = 40'h14_7F_14_7F_14;
            7'h24: r = 40'h24_2A_7F_2A_12;
            7'h25: r = 40'h23_13_08_64_62;
            7'h26: r = 40'h36_49_55_22_50;
            7'h27: r = 40'h00_05_03_00_00;
            7'h28: r = 40'h00_1C_22_41_00;
            7'h29: r = 40'h00_41_22_1C_00;
            7'h2A: r = 40'h08_2A_1C_2A_08;
            7'h2B: r = 40'h08_08_3E_08_08;
            7'h2C: r = 40'h00_50_30_00_00;
            7'h2D: r = 40'h08_08_08_08_08;
            7'h2E: r = 40'h00_60_60_00_00;
            7'h2F: r = 40'h20_10_08_04_02;
            7'h30: r = 40'h3E_51_49_45_3E;
            7'h31: r = 40'h00_42_7F_40_00;
            7'h32: r = 40'h42_61_51_49_46;
            7'h33: r = 40'h21_41_45_4B_31;
            7'h34: r = 40'h18_14_12_7F_10;
            7'h35: r = 40'h27_45_45_45_39;
            7'h36: r = 40'h3C_4A_49_49_30;
            7'h37: r = 40'h01_71_09_05_03;
            7'h38: r = 40'h36_49_49_49_36;
            7'h39: r = 40'h06_49_49_29_1E;
            7'h3A: r = 40'h00_36_36_00_00;
            7'h3B: r = 40'h00_56_36_00_00;
            7'h3C: r = 40'h00_08_14_22_41;
            7'h3D: r = 40'h14_14_14_14_14;
            7'h3E: r = 40'h41_22_14_08_00;
            7'h3F: r = 40'h02_01_51_09_06;
            default: r = 40'h00_00_00_00_00;
        endcase
        return r;
    endfunction : glyph_row

    // One glyph column; column 5 shifts everything out and gives the blank spacer
    function automatic logic [7:0] glyph_col(input logic [4:0] code, input logic [2:0] col);
        logic [39:0] sh;
        sh = glyph_row(7'({2'b00, code}) + `POV_ASCII_OFFSET) << (col * 8);
        return sh[39:32];
    endfunction : glyph_col

    // Pin synchroniser
    pov_pins_t pins_raw;
    pov_pins_t sync1_r;
    pov_pins_t sync2_r;
    logic step_prev_r;

    // Word assembly and storage
    logic [7:0] shreg_r;
    logic [7:0] shreg_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    pov_word_t mem_r [`POV_DEPTH];
    logic [`POV_CNT_W-1:0] count_r;
    logic [`POV_CNT_W-1:0] count_nxt;

    // Playback pointers and LED column
    logic [`POV_IDX_W-1:0] rd_idx_r;
    logic [`POV_IDX_W-1:0] rd_idx_nxt;
    logic [2:0] col_r;
    logic [2:0] col_nxt;
    pov_state_t state_r;
    pov_state_t state_nxt;
    logic [7:0] led_r;
    logic [7:0] led_nxt;

    // Pin bundle; every pin is foreign to the core clock
    assign pins_raw = {step_clk_i, write_i, din_i, under_i, over_i};

    // Two-stage synchroniser plus one edge-history flop behind it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            step_prev_r <= 1'b0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            step_prev_r <= sync2_r.step;
        end
    end

    // Step decode: one action per rising step edge
    wire step_edge = sync2_r.step & ~step_prev_r;
    wire shift_en = step_edge & sync2_r.write;
    wire disp_en = step_edge & ~sync2_r.write;

    // Word assembly: first bit lands in bit 0 after eight shifts
    assign shreg_nxt = shift_en ? {sync2_r.din, shreg_r[7:1]} : shreg_r;
    assign bit_cnt_nxt = shift_en ? 3'(bit_cnt_r + 3'h1) : bit_cnt_r;
    wire word_done = shift_en & (bit_cnt_r == `POV_LAST_BIT);
    wire [7:0] word_full = shreg_nxt;
    wire [6:0] word_dec = word_full[6:0];

    // Word classification; codes 1x other than all-ones are dropped
    wire is_show = (word_dec == `POV_SHOW_CODE);
    wire is_store = ~word_dec[6];
    wire fresh = (state_r == POV_ST_SHOW);
    wire full = ~fresh & (count_r == `POV_DEPTH_CNT);
    wire store_en = word_done & is_store & ~full;
    wire show_go = word_done & is_show;
    wire [`POV_IDX_W-1:0] wr_idx = fresh ? '0 : count_r[`POV_IDX_W-1:0];

    // New data after playback starts a fresh buffer
    assign count_nxt = store_en ? (fresh ? 5'h01 : 5'(count_r + 5'h01)) : count_r;

    // Load/show sequencing; an all-ones word and a storable word never coincide
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            POV_ST_LOAD: begin
                if (show_go) begin
                    state_nxt = POV_ST_SHOW;
                end
            end
            POV_ST_SHOW: begin
                if (store_en) begin
                    state_nxt = POV_ST_LOAD;
                end
            end
            default: begin
                state_nxt = POV_ST_LOAD;
            end
        endcase
    end

    // Playback decode for the word under the read pointer
    wire [6:0] cur = mem_r[rd_idx_r];
    wire cur_chr = (pov_kind_t'(cur[6:5]) == POV_KIND_CHR);
    wire [2:0] last_col = cur_chr ? `POV_CHR_LAST_COL : `POV_BMP_LAST_COL;
    wire [7:0] bmp_col = {1'b0, sync2_r.under, cur[4:0], sync2_r.over};
    wire [7:0] col_data = cur_chr ? glyph_col(cur[4:0], col_r) : bmp_col;
    wire disp_go = disp_en & (state_r == POV_ST_SHOW) & (count_r != `POV_RST_CNT);
    wire col_wrap = (col_r == last_col);
    wire idx_wrap = (5'({1'b0, rd_idx_r}) + 5'h01) == count_r;

    // Column and word pointers; playback restarts at the first column
    wire [2:0] col_adv = col_wrap ? 3'h0 : 3'(col_r + 3'h1);
    wire [`POV_IDX_W-1:0] idx_adv = idx_wrap ? '0 : 4'(rd_idx_r + 4'h1);
    wire word_end = disp_go & col_wrap;
    assign col_nxt = show_go ? 3'h0 : (disp_go ? col_adv : col_r);
    assign rd_idx_nxt = show_go ? '0 : (word_end ? idx_adv : rd_idx_r);
    assign led_nxt = disp_go ? col_data : led_r;

    // Shifter state; reset clears the bit position, a partial word is lost
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shreg_r <= `POV_RST_SHREG;
            bit_cnt_r <= `POV_RST_BIT;
        end else begin
            shreg_r <= shreg_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // Store count and mode; the words themselves survive reset
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= `POV_RST_CNT;
            state_r <= POV_ST_LOAD;
        end else begin
            count_r <= count_nxt;
            state_r <= state_nxt;
        end
    end

    // Playback position and LED column; reset clears the column position
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_idx_r <= `POV_RST_IDX;
            col_r <= `POV_RST_COL;
            led_r <= `POV_RST_LED;
        end else begin
            rd_idx_r <= rd_idx_nxt;
            col_r <= col_nxt;
            led_r <= led_nxt;
        end
    end

    // Word storage has no reset; only counted slots are ever read
    always_ff @(posedge core_clk_i) begin
        if (store_en) begin
            mem_r[wr_idx] <= word_dec;
        end
    end

    assign led_o = led_r;
    assign showing_o = (state_r == POV_ST_SHOW);

endmodule : pov_char_rom_serial_shifter

`default_nettype wire

// ### tb/pov_src.sv
`default_nettype none
module pov_src
    import pov_pkg::*;
(
    input wire logic clk_i, // Clock
    output var pov_pins_t pins_o); // Pins
    timeunit 1ns / 1ps;
    initial pins_o = '0;
    // Pins hold 4 cycles each side of the pulse, past the 3-flop sync
    task automatic step(input logic w, d, u, o);
        @(negedge clk_i) pins_o = {1'b0, w, d, u, o};
        for (int k = 0; k < 3; k++) begin
            repeat (4) @(negedge clk_i);
            pins_o.step = (k == 0);
        end
    endtask : step
    // Word leaves least significant bit first
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) step(1'b1, b[i], 1'b0, 1'b0);
    endtask : send
endmodule : pov_src
`default_nettype wire

// ### tb/pov_char_rom_serial_shifter_monitor.sv
`default_nettype none
module pov_monitor (
    input wire logic core_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic step_clk_i, // Step
    input wire logic write_i, // Mode
    input wire logic [7:0] led_o, // Column
    input wire logic showing_o); // Playback
    timeunit 1ns / 1ps;
    // Sync lag is 3 cycles, so quiet spans of 6 hold every effect off
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_top_bit_dark: assert property (led_o[7] == 1'b0) else $error("bit 7 lit");
    a_reset_clears_all: assert property ($fell(rst_i) |-> led_o == 8'h00 && !showing_o) else $error("no clear");
    a_shift_keeps_led: assert property (write_i [*6] |=> $stable(led_o)) else $error("led moved");
    a_idle_keeps_led: assert property (!step_clk_i [*6] |=> $stable(led_o)) else $error("led drift");
    a_idle_keeps_show: assert property (!step_clk_i [*6] |=> $stable(showing_o)) else $error("show drift");
    a_play_no_entry: assert property (!write_i [*6] |=> !$rose(showing_o)) else $error("show rose");
    a_load_keeps_led: assert property (!showing_o |=> $stable(led_o)) else $error("led in load");
    a_entry_keeps_led: assert property ($rose(showing_o) |-> $stable(led_o)) else $error("led at entry");
endmodule : pov_monitor
bind pov_char_rom_serial_shifter pov_monitor mon_i (.core_clk_i, .rst_i, .step_clk_i, .write_i, .led_o, .showing_o);
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns / 1ps;
    logic core_clk_i = 1'b0, rst_i = 1'b1;
    logic show, ms = 1'b0;
    logic [7:0] led, exp = 8'h00, q[$];
    pov_pkg::pov_pins_t pins;
    int n_mismatch = 0, num_checks = 0, p = 0, c = 0;
    pov_char_rom_serial_shifter pov_char_rom_serial_shifter_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .step_clk_i(pins.step), .write_i(pins.write), .din_i(pins.din), .under_i(pins.under),
        .over_i(pins.over), .led_o(led), .showing_o(show));
    pov_src pov_src_i (.clk_i(core_clk_i), .pins_o(pins));
    // 4 ns clock
    initial forever #2 core_clk_i = ~core_clk_i;
    // Compare and count
    task automatic check(input logic [7:0] s, e);
        num_checks++;
        n_mismatch += (s !== e);
        if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
    endtask : check
    // Verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Expected column; the only character loaded is '!', lit in its third column
    function automatic logic [7:0] exp_col(input logic [7:0] w, input int k, input logic u, o);
        return w[5] ? ((k == 2) ? 8'h5F : 8'h00) : {1'b0, u, w[4:0], o};
    endfunction : exp_col
    // Model: 16 slots, a storable word in playback restarts the list
    task automatic load(input logic [7:0] w);
        pov_src_i.send(w);
        if (w[6:0] == 7'h7F) {ms, p, c} = {1'b1, 64'h0};
        else if (!w[6] && ms) q = {w};
        else if (!w[6] && q.size() < 16) q.push_back(w);
        ms = ms && w[6];
        check({7'h00, show}, {7'h00, ms});
    endtask : load
    // A glyph gives six columns, a bitmap one; refused steps keep led
    task automatic play(input logic u, o);
        pov_src_i.step(1'b0, u, u, o);
        if (ms && q.size() > 0) begin
            exp = exp_col(q[p], c, u, o);
            c = (q[p][5] && c < 5) ? c + 1 : 0;
            p = (c == 0) ? (p + 1) % q.size() : p;
        end
        check(led, exp);
    endtask : play
    // Random words past the 16-slot limit, restart, refusal, reset mid-word
    initial begin
        void'($urandom(31813));
        #16 rst_i = 1'b0;
        load({1'($urandom), 7'h21});
        for (int i = 0; i < 17; i++) load({1'($urandom), 2'b00, 5'($urandom)});
        load(8'hFF);
        for (int i = 0; i < 25; i++) play(1'($urandom), 1'($urandom));
        load(8'h0A);
        play(1'b1, 1'b0);
        load(8'h7F);
        repeat (2) play(1'b0, 1'b1);
        repeat (3) pov_src_i.step(1'b1, 1'b1, 1'b0, 1'b0);
        rst_i = 1'b1;
        #16 rst_i = 1'b0;
        q = {};
        {ms, exp, p, c} = '0;
        check(led, exp);
        load(8'h7F);
        play(1'b1, 1'b1);
        load({1'($urandom), 2'b10, 5'($urandom)});
        load(8'h21);
        load(8'hFF);
        load(8'hE3);
        repeat (7) play(1'b0, 1'b0);
        end_sim();
    end
endmodule : tb
`default_nettype wire
